// ---- oad_pkg.sv ----
// Purpose: shared constants and types of the operand address decoder
// Assumes: 16-bit instructions, 32-bit registers and addresses
// Notes:   field positions, size codes, steps and mode list are defined here
package oad_pkg;

  // ==========================================================================
  // instruction field positions
  localparam int HI_FIELD_MSB  = 11;
  localparam int HI_FIELD_LSB  = 8;
  localparam int LO_FIELD_MSB  = 7;
  localparam int LO_FIELD_LSB  = 4;
  localparam int DISP4_MSB     = 3;
  localparam int DISP8_MSB     = 7;
  localparam int DISP12_MSB    = 11;
  localparam int OPCLASS_LSB   = 12;

  // ==========================================================================
  // operand size codes and the address steps that go with them
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG = 32'h0000_0004;

  localparam logic [3:0]  REG_ZERO_IDX = 4'h0;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

  // ==========================================================================
  // addressing modes chosen by the opcode decode ahead of this block
  typedef enum logic [3:0] {
    MODE_NONE,
    MODE_REG_DIRECT,
    MODE_INDIRECT,
    MODE_POST_INC,
    MODE_PRE_DEC,
    MODE_DISP4,
    MODE_INDEXED,
    MODE_GBR_DISP,
    MODE_PC_DISP8,
    MODE_PC_DISP12,
    MODE_PC_REG,
    MODE_PC_CONST,
    MODE_IMM_ZERO,
    MODE_IMM_SIGN,
    MODE_IMM_TRAP,
    MODE_MAC
  } oad_mode_type;

endpackage

// ---- oad_ext.sv ----
// Purpose: displacement scaling and immediate / load data extension
// Assumes: purely combinational, used by the decoder core
// Notes:   all results are full 32-bit words
`timescale 1ns/1ps
`default_nettype none

module oad_ext (
  input  wire logic [15:0] instr,
  input  wire logic [1:0]  op_size,
  input  wire logic [1:0]  load_size,
  input  wire logic [31:0] load_data,
  output logic      [31:0] step,
  output logic      [31:0] disp4_scaled,
  output logic      [31:0] disp8_scaled,
  output logic      [31:0] pc8_offset,
  output logic      [31:0] pc12_offset,
  output logic      [31:0] imm_zero_ext,
  output logic      [31:0] imm_sign_ext,
  output logic      [31:0] imm_trap,
  output logic      [31:0] load_ext
);

  logic [31:0] d4_zx;
  logic [31:0] d8_zx;

  // ==========================================================================
  // raw fields, zero-extended
  assign d4_zx = {28'h000_0000, instr[oad_pkg::DISP4_MSB:0]};
  assign d8_zx = {24'h00_0000, instr[oad_pkg::DISP8_MSB:0]};

  // scaling by operand size; unknown size codes fall back to byte
  always_comb begin
    case (op_size)
      oad_pkg::SIZE_WORD: begin
        step         = oad_pkg::STEP_WORD;
        disp4_scaled = {d4_zx[30:0], 1'b0};
        disp8_scaled = {d8_zx[30:0], 1'b0};
      end
      oad_pkg::SIZE_LONG: begin
        step         = oad_pkg::STEP_LONG;
        disp4_scaled = {d4_zx[29:0], 2'h0};
        disp8_scaled = {d8_zx[29:0], 2'h0};
      end
      default: begin
        step         = oad_pkg::STEP_BYTE;
        disp4_scaled = d4_zx;
        disp8_scaled = d8_zx;
      end
    endcase
  end

  // branch offsets are sign-extended then doubled
  assign pc8_offset   = {{23{instr[7]}}, instr[7:0], 1'b0};
  assign pc12_offset  = {{19{instr[11]}}, instr[11:0], 1'b0};
  assign imm_zero_ext = d8_zx;
  assign imm_sign_ext = {{24{instr[7]}}, instr[7:0]};
  assign imm_trap     = {d8_zx[29:0], 2'h0};

  // memory data narrower than a longword is sign-extended into the register
  always_comb begin
    case (load_size)
      oad_pkg::SIZE_BYTE: load_ext = {{24{load_data[7]}}, load_data[7:0]};
      oad_pkg::SIZE_WORD: load_ext = {{16{load_data[15]}}, load_data[15:0]};
      default:            load_ext = load_data;
    endcase
  end

endmodule

`default_nettype wire

// ---- oad_core.sv ----
// Purpose: operand field decode and effective address generation
// Assumes: register values for both register fields, register zero, global
//          base and program counter arrive with the instruction
// Notes:   one registered stage; results are valid the edge after a take
//
// Contract
// - register direct: operand is the register named by the field, no memory access
// - register indirect: address is the selected register unmodified
// - post-increment: address is register; then register grows by 1, 2 or 4
// - pre-decrement: register drops by 1, 2 or 4 first; address is new value
// - 4-bit displacement zero-extended, scaled by size, added to register
// - indexed: address is selected register plus register zero
// - 8-bit displacement zero-extended, scaled by size, added to global base
// - short pc form: 8-bit displacement sign-extended, doubled, plus pc
// - long pc form: 12-bit displacement sign-extended, doubled, plus pc
// - register pc form: target is pc plus selected register
// - bit-test and logic immediates are zero-extended to 32 bits
// - move, add and compare-equal immediates are sign-extended
// - trap immediate zero-extended and multiplied by four
// - three-field format: destination 11:8, source 7:4, displacement 3:0
// - 8-bit displacement format takes bits 7:0 as displacement
// - 12-bit format: top four bits select operation, 11:0 displacement
// - register plus 8-bit: destination 11:8, pc displacement 7:0
// - 4-bit store format: base 7:4, displacement 3:0, register zero data
// - register-immediate format: destination 11:8, immediate 7:0
// - multiply-accumulate: destination field is a second post-incremented source
// - misaligned word or longword address raises an address error
// - byte and word loads are sign-extended to 32 bits
`timescale 1ns/1ps
`default_nettype none

module oad_core (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic                 dec_valid,
  input  wire logic [15:0]          instr,
  input  wire oad_pkg::oad_mode_type mode,
  input  wire logic [1:0]           op_size,
  input  wire logic                 base_in_low,
  input  wire logic                 is_store,
  input  wire logic [31:0]          hi_field_value,
  input  wire logic [31:0]          lo_field_value,
  input  wire logic [31:0]          register_zero,
  input  wire logic [31:0]          global_base,
  input  wire logic [31:0]          pc_value,
  input  wire logic                 load_valid,
  input  wire logic [1:0]           load_size,
  input  wire logic [31:0]          load_data,
  output logic                      out_valid,
  output logic [3:0]                op_class,
  output logic [3:0]                dest_reg_field,
  output logic [3:0]                src_reg_field,
  output logic                      operand_is_reg,
  output logic [3:0]                operand_reg,
  output logic [3:0]                xfer_reg,
  output logic                      mem_req,
  output logic [31:0]               mem_addr,
  output logic                      mem2_req,
  output logic [31:0]               mem2_addr,
  output logic                      addr_error,
  output logic                      wb0_en,
  output logic [3:0]                wb0_idx,
  output logic [31:0]               wb0_data,
  output logic                      wb1_en,
  output logic [3:0]                wb1_idx,
  output logic [31:0]               wb1_data,
  output logic                      imm_valid,
  output logic [31:0]               imm_value,
  output logic                      target_valid,
  output logic [31:0]               target,
  output logic                      to_mult_acc,
  output logic                      load_ext_valid,
  output logic [31:0]               load_ext
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic        valid;
    logic [3:0]  op_class;
    logic [3:0]  dest_f;
    logic [3:0]  src_f;
    logic        op_is_reg;
    logic [3:0]  op_reg;
    logic [3:0]  xfer;
    logic        mreq;
    logic [31:0] maddr;
    logic        mreq2;
    logic [31:0] maddr2;
    logic        aerr;
    logic        w0_en;
    logic [3:0]  w0_idx;
    logic [31:0] w0_data;
    logic        w1_en;
    logic [3:0]  w1_idx;
    logic [31:0] w1_data;
    logic        imm_v;
    logic [31:0] imm;
    logic        tgt_v;
    logic [31:0] tgt;
    logic        mac;
    logic        ld_v;
    logic [31:0] ld;
  } oad_state_type;

  oad_state_type state_reg;
  oad_state_type state_next;

  logic [31:0] step;
  logic [31:0] disp4_scaled;
  logic [31:0] disp8_scaled;
  logic [31:0] pc8_offset;
  logic [31:0] pc12_offset;
  logic [31:0] imm_zero_ext;
  logic [31:0] imm_sign_ext;
  logic [31:0] imm_trap;
  logic [31:0] load_ext_w;
  logic [3:0]  hi_f;
  logic [3:0]  lo_f;
  logic [3:0]  base_idx;
  logic [31:0] base_val;
  logic        take;

  // ==========================================================================
  // field extraction and extension
  oad_ext u_ext (
    .instr        (instr),
    .op_size      (op_size),
    .load_size    (load_size),
    .load_data    (load_data),
    .step         (step),
    .disp4_scaled (disp4_scaled),
    .disp8_scaled (disp8_scaled),
    .pc8_offset   (pc8_offset),
    .pc12_offset  (pc12_offset),
    .imm_zero_ext (imm_zero_ext),
    .imm_sign_ext (imm_sign_ext),
    .imm_trap     (imm_trap),
    .load_ext     (load_ext_w)
  );

  // register fields sit at fixed places in every format
  assign hi_f     = instr[oad_pkg::HI_FIELD_MSB:oad_pkg::HI_FIELD_LSB];
  assign lo_f     = instr[oad_pkg::LO_FIELD_MSB:oad_pkg::LO_FIELD_LSB];
  // short formats carry their base in bits 7:4, others in 11:8
  assign base_idx = base_in_low ? lo_f : hi_f;
  assign base_val = base_in_low ? lo_field_value : hi_field_value;
  assign take     = ce && dec_valid;

  // misalignment only matters for word and longword accesses
  function automatic logic misaligned(input logic [1:0] sz, input logic [31:0] a);
    misaligned = ((sz == oad_pkg::SIZE_WORD) && a[0]) ||
                 ((sz == oad_pkg::SIZE_LONG) && (a[1:0] != 2'h0));
  endfunction

  // ==========================================================================
  // next state: one decode per take; pulses drop on an edge with ce high that takes nothing
  always_comb begin
    state_next          = state_reg;
    state_next.valid    = 1'b0;
    state_next.ld_v     = 1'b0;
    if (ce && load_valid) begin
      state_next.ld_v = 1'b1;
      state_next.ld   = load_ext_w;
    end
    if (ce) begin
      state_next.mreq  = 1'b0;
      state_next.mreq2 = 1'b0;
      state_next.w0_en = 1'b0;
      state_next.w1_en = 1'b0;
      state_next.imm_v = 1'b0;
      state_next.tgt_v = 1'b0;
      state_next.aerr  = 1'b0;
    end
    if (take) begin
      state_next.valid     = 1'b1;
      state_next.op_class  = instr[15:oad_pkg::OPCLASS_LSB];
      state_next.dest_f    = hi_f;
      state_next.src_f     = lo_f;
      state_next.op_is_reg = 1'b0;
      state_next.op_reg    = base_idx;
      state_next.mac       = 1'b0;
      state_next.w0_idx    = base_idx;
      // data register: short and global-base forms move register zero; the pc table constant case below overrides it
      if (base_in_low || mode == oad_pkg::MODE_GBR_DISP)
        state_next.xfer = oad_pkg::REG_ZERO_IDX;
      else
        state_next.xfer = is_store ? lo_f : hi_f;
      // sums below are 32 bits wide and wrap silently
      case (mode)
        oad_pkg::MODE_REG_DIRECT: begin
          state_next.op_is_reg = 1'b1;
        end
        oad_pkg::MODE_INDIRECT: begin
          state_next.mreq  = 1'b1;
          state_next.maddr = base_val;
        end
        oad_pkg::MODE_POST_INC: begin
          state_next.mreq    = 1'b1;
          state_next.maddr   = base_val;
          state_next.w0_en   = 1'b1;
          state_next.w0_data = base_val + step;
        end
        oad_pkg::MODE_PRE_DEC: begin
          state_next.mreq    = 1'b1;
          state_next.maddr   = base_val - step;
          state_next.w0_en   = 1'b1;
          state_next.w0_data = base_val - step;
        end
        oad_pkg::MODE_DISP4: begin
          state_next.mreq  = 1'b1;
          state_next.maddr = base_val + disp4_scaled;
        end
        oad_pkg::MODE_INDEXED: begin
          state_next.mreq  = 1'b1;
          state_next.maddr = base_val + register_zero;
        end
        oad_pkg::MODE_GBR_DISP: begin
          state_next.mreq  = 1'b1;
          state_next.maddr = global_base + disp8_scaled;
        end
        oad_pkg::MODE_PC_DISP8: begin
          state_next.tgt_v = 1'b1;
          state_next.tgt   = pc_value + pc8_offset;
        end
        oad_pkg::MODE_PC_DISP12: begin
          state_next.tgt_v = 1'b1;
          state_next.tgt   = pc_value + pc12_offset;
        end
        oad_pkg::MODE_PC_REG: begin
          state_next.tgt_v = 1'b1;
          state_next.tgt   = pc_value + base_val;
        end
        oad_pkg::MODE_PC_CONST: begin
          // constant load from a pc-relative table into the high field
          state_next.mreq  = 1'b1;
          state_next.maddr = pc_value + disp8_scaled;
          state_next.xfer  = hi_f;
        end
        oad_pkg::MODE_IMM_ZERO: begin
          state_next.imm_v = 1'b1;
          state_next.imm   = imm_zero_ext;
        end
        oad_pkg::MODE_IMM_SIGN: begin
          state_next.imm_v  = 1'b1;
          state_next.imm    = imm_sign_ext;
          state_next.op_reg = hi_f;
        end
        oad_pkg::MODE_IMM_TRAP: begin
          state_next.imm_v = 1'b1;
          state_next.imm   = imm_trap;
        end
        oad_pkg::MODE_MAC: begin
          // both fields are sources; results go to the accumulator pair
          state_next.mac     = 1'b1;
          state_next.mreq    = 1'b1;
          state_next.maddr   = lo_field_value;
          state_next.mreq2   = 1'b1;
          state_next.maddr2  = hi_field_value;
          state_next.w0_en   = 1'b1;
          state_next.w0_idx  = lo_f;
          state_next.w0_data = lo_field_value + step;
          state_next.w1_en   = 1'b1;
          state_next.w1_idx  = hi_f;
          state_next.w1_data = hi_field_value + step;
        end
        default: begin
        end
      endcase
      // an access that would fault still reports its address
      state_next.aerr = (state_next.mreq && misaligned(op_size, state_next.maddr)) ||
                        (state_next.mreq2 && misaligned(op_size, state_next.maddr2));
    end
  end

  // ==========================================================================
  // state register; ce low freezes everything
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state flops
  // field order of the state struct matches the output list one for one
  assign {out_valid, op_class, dest_reg_field, src_reg_field, operand_is_reg, operand_reg,
          xfer_reg, mem_req, mem_addr, mem2_req, mem2_addr, addr_error, wb0_en, wb0_idx,
          wb0_data, wb1_en, wb1_idx, wb1_data, imm_valid, imm_value, target_valid, target,
          to_mult_acc, load_ext_valid, load_ext} = state_reg;

  // ==========================================================================
  // checks
  reg_direct_nomem_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && mode == oad_pkg::MODE_REG_DIRECT) |=> (operand_is_reg && !mem_req
      && operand_reg == $past(base_idx)))
    else $error("register direct made a memory access");
  indirect_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && mode == oad_pkg::MODE_INDIRECT) |=> (mem_req && mem_addr == $past(base_val)))
    else $error("indirect address differs from register");
  post_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && mode == oad_pkg::MODE_POST_INC && op_size == oad_pkg::SIZE_LONG)
      |=> (mem_addr == $past(base_val) && wb0_data == mem_addr + 32'h0000_0004))
    else $error("post-increment address or update wrong");
  pre_dec_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && mode == oad_pkg::MODE_PRE_DEC && op_size == oad_pkg::SIZE_WORD)
      |=> (mem_addr == $past(base_val) - 32'h0000_0002 && wb0_data == mem_addr))
    else $error("pre-decrement address or update wrong");
  indexed_sum_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && mode == oad_pkg::MODE_INDEXED)
      |=> (mem_addr == $past(base_val) + $past(register_zero)))
    else $error("indexed address is not the sum");
  // any negative displacement with raw byte u lands 512 - 2u below the pc
  pc_short_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && mode == oad_pkg::MODE_PC_DISP8 && instr[7])
      |=> (target_valid && target == $past(pc_value) - (32'h0000_0200
        - {23'h00_0000, $past(instr[7:0]), 1'b0})))
    else $error("short pc target wrong for negative displacement");
  trap_scale_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && mode == oad_pkg::MODE_IMM_TRAP)
      |=> (imm_valid && imm_value[1:0] == 2'h0 && imm_value[31:10] == 22'h00_0000))
    else $error("trap immediate not quadrupled zero-extended");
  align_err_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && op_size == oad_pkg::SIZE_LONG)
      |=> (!mem_req || mem_addr[1:0] == 2'h0 || addr_error))
    else $error("misaligned longword access not flagged");
  mac_sources_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && mode == oad_pkg::MODE_MAC)
      |=> (to_mult_acc && wb0_en && wb1_en && wb1_idx == $past(hi_f)))
    else $error("multiply-accumulate sources not both advanced");

endmodule

`default_nettype wire

// ---- oad_regfile_model.sv ----
// Purpose: register file model feeding the decoder and taking its updates
// Assumes: writes land on the edge after the decoder pulses its enables
// Notes:   reset fills a fixed pattern so addresses are spread and known
`timescale 1ns/1ps
`default_nettype none
module oad_regfile_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] instr,
  input  wire logic        wb0_en,
  input  wire logic [3:0]  wb0_idx,
  input  wire logic [31:0] wb0_data,
  input  wire logic        wb1_en,
  input  wire logic [3:0]  wb1_idx,
  input  wire logic [31:0] wb1_data,
  output logic      [31:0] hi_value,
  output logic      [31:0] lo_value,
  output logic      [31:0] r0_value
);
  logic [31:0] regs [16];
  // ====================================================
  // reads follow the fields at once, as a real file port would
  assign hi_value = regs[instr[11:8]];
  assign lo_value = regs[instr[7:4]];
  assign r0_value = regs[0];
  // second port written last so it wins a same-index clash
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) regs[i] <= 32'h9e37_79b9 * (i + 1);
    end else begin
      if (wb0_en) regs[wb0_idx] <= wb0_data;
      if (wb1_en) regs[wb1_idx] <= wb1_data;
    end
  end
endmodule
`default_nettype wire

// ---- tb_operand_address_decode.sv ----
// Purpose: random self-checking run of the operand address decoder
// Assumes: inputs change on the falling edge, results read one cycle later
// Notes:   clock enable drops at random; every mode is reached by random choice
`timescale 1ns/1ps
`default_nettype none
module tb_operand_address_decode;
  logic clk, rst_n, dv, bil, sto, lv, ov, mrq, m2r, aer, w0e, w1e, iv, tv, lev, cen, oir, mac;
  logic [15:0] ins;
  logic [1:0] sz, lsz;
  logic [3:0] w0i, w1i, oc, df, sf, opr, xr, bi, e_x, e_w1i;
  logic [6:0] e_fl;
  logic [23:0] e_fd;
  logic [31:0] hv, lov, r0, gb, pc, ld, ma, m2a, w0d, w1d, imm, tg, lx, s, a, a2, st, bs;
  oad_pkg::oad_mode_type md;
  int bad_count, num_checks;
  logic e_v, e_req, e_wb, e_t, e_i, e_mac, e_lv;
  logic [31:0] e_a, e_a2, e_w, e_val, e_lx, e_w1;
  logic [1:0] e_sz;
  oad_core DUT (.clk(clk), .rst_n(rst_n), .ce(cen), .dec_valid(dv), .instr(ins), .mode(md),
    .op_size(sz), .base_in_low(bil), .is_store(sto), .hi_field_value(hv),
    .lo_field_value(lov), .register_zero(r0), .global_base(gb), .pc_value(pc),
    .load_valid(lv), .load_size(lsz), .load_data(ld), .out_valid(ov), .op_class(oc),
    .dest_reg_field(df), .src_reg_field(sf), .operand_is_reg(oir), .operand_reg(opr),
    .xfer_reg(xr), .mem_req(mrq), .mem_addr(ma), .mem2_req(m2r), .mem2_addr(m2a),
    .addr_error(aer), .wb0_en(w0e), .wb0_idx(w0i), .wb0_data(w0d), .wb1_en(w1e),
    .wb1_idx(w1i), .wb1_data(w1d), .imm_valid(iv), .imm_value(imm), .target_valid(tv),
    .target(tg), .to_mult_acc(mac), .load_ext_valid(lev), .load_ext(lx));
  oad_regfile_model rf (.clk(clk), .rst_n(rst_n), .instr(ins), .wb0_en(w0e), .wb0_idx(w0i),
    .wb0_data(w0d), .wb1_en(w1e), .wb1_idx(w1i), .wb1_data(w1d), .hi_value(hv),
    .lo_value(lov), .r0_value(r0));
  // ====================================================
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic mis(input logic [31:0] x, input logic [1:0] z);
    return (z == 2'h1 && x[0]) || (z == 2'h2 && x[1:0] != 2'h0);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ====================================================
  // each falling edge checks last cycle's take, then drives the next one
  initial begin
    {rst_n, dv, bil, sto, lv, cen, e_v, e_lv} = '0;
    {ins, sz, lsz, gb, pc, ld} = '0;
    md = oad_pkg::MODE_NONE;
    s = 32'h0000_0056;
    repeat (5) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    for (int n = 0; n < 3000; n++) begin
      @(negedge clk);
      chk({31'h0, ov}, {31'h0, e_v});
      if (e_v) begin
        chk({31'h0, mrq}, {31'h0, e_req});
        if (e_req) chk(ma, e_a);
        if (e_req) chk({31'h0, aer}, {31'h0, mis(e_a, e_sz) | (e_mac & mis(e_a2, e_sz))});
        if (e_mac) chk(m2a, e_a2);
        if (e_mac) chk(w1d, e_w1);
        if (e_mac) chk({28'h0, w1i}, {28'h0, e_w1i});
        chk({25'h0, oir, w0e, w1e, m2r, iv, tv, mac}, {25'h0, e_fl});
        chk({8'h0, oc, df, sf, opr, xr, w0i}, {8'h0, e_fd});
        if (e_wb) chk(w0d, e_w);
        if (e_t) chk(tg, e_val);
        if (e_i) chk(imm, e_val);
      end
      chk({31'h0, lev}, {31'h0, e_lv});
      if (e_lv) chk(lx, e_lx);
      s = lfsr(lfsr(s)); ins = s[15:0]; md = oad_pkg::oad_mode_type'(s[19:16]);
      sz = 2'(s[22:20] % 3); bil = s[23]; sto = s[24]; dv = s[27:25] != 3'h0;
      s = lfsr(lfsr(s)); gb = s; pc = {s[15:0], s[31:16]};
      s = lfsr(lfsr(s)); ld = s; lv = s[5]; lsz = 2'(s[9:8] % 3); cen = s[12:10] != 3'h0;
      #1;
      // an edge with the enable low takes nothing, so the old expectations still stand
      if (cen) begin
        bs = bil ? lov : hv; st = 32'h1 << sz; bi = bil ? ins[7:4] : ins[11:8];
        {e_req, e_wb, e_t, e_i, e_mac} = '0; e_v = dv; e_sz = sz; a = bs; a2 = hv;
        case (md)
          oad_pkg::MODE_INDIRECT: e_req = 1'b1;
          oad_pkg::MODE_POST_INC: begin e_req = 1'b1; e_wb = 1'b1; e_w = bs + st; end
          oad_pkg::MODE_PRE_DEC: begin e_req = 1'b1; e_wb = 1'b1; a = bs - st; e_w = a; end
          oad_pkg::MODE_DISP4: begin e_req = 1'b1; a = bs + ({28'h0, ins[3:0]} << sz); end
          oad_pkg::MODE_INDEXED: begin e_req = 1'b1; a = bs + r0; end
          oad_pkg::MODE_GBR_DISP: begin e_req = 1'b1; a = gb + ({24'h0, ins[7:0]} << sz); end
          oad_pkg::MODE_PC_CONST: begin e_req = 1'b1; a = pc + ({24'h0, ins[7:0]} << sz); end
          oad_pkg::MODE_MAC: begin
            e_req = 1'b1; e_mac = 1'b1; e_wb = 1'b1; a = lov; e_w = lov + st;
            e_w1 = hv + st; e_w1i = ins[11:8];
          end
          oad_pkg::MODE_PC_DISP8: begin
            e_t = 1'b1; e_val = pc + {{23{ins[7]}}, ins[7:0], 1'b0};
          end
          oad_pkg::MODE_PC_DISP12: begin
            e_t = 1'b1; e_val = pc + {{19{ins[11]}}, ins[11:0], 1'b0};
          end
          oad_pkg::MODE_PC_REG: begin e_t = 1'b1; e_val = pc + bs; end
          oad_pkg::MODE_IMM_ZERO: begin e_i = 1'b1; e_val = {24'h0, ins[7:0]}; end
          oad_pkg::MODE_IMM_SIGN: begin e_i = 1'b1; e_val = {{24{ins[7]}}, ins[7:0]}; end
          oad_pkg::MODE_IMM_TRAP: begin e_i = 1'b1; e_val = {22'h0, ins[7:0], 2'h0}; end
          default: e_req = 1'b0;
        endcase
        // short and global-base forms move register zero, table constants go to 11:8
        e_x = (md == oad_pkg::MODE_PC_CONST) ? ins[11:8] :
              (bil || md == oad_pkg::MODE_GBR_DISP) ? 4'h0 : sto ? ins[7:4] : ins[11:8];
        e_fl = {md == oad_pkg::MODE_REG_DIRECT, e_wb, e_mac, e_mac, e_i, e_t, e_mac};
        e_fd = {ins[15:4], ((md == oad_pkg::MODE_IMM_SIGN) ? ins[11:8] : bi), e_x,
                (e_mac ? ins[7:4] : bi)};
        e_a = a; e_a2 = a2; e_lv = lv;
        e_lx = lsz == 2'h0 ? {{24{ld[7]}}, ld[7:0]} :
               lsz == 2'h1 ? {{16{ld[15]}}, ld[15:0]} : ld;
      end
    end
    final_report();
  end
endmodule
`default_nettype wire
